// >>> include/itv_pkg.sv
// package: constants, types and register map of the interrupt and trap vectoring block
// Notes on behaviour
// - each node has request, enable and fixed vector; nodes span 0x60..0x11C.
// - hardware trap reacts at once, cannot be masked, branches to its vector.
// - each hardware trap kind sets its own bit in the trap flag register.
// - pending trap interrupts program unless equal or higher priority trap service is active.
// - during trap service, standard interrupts and event transfers do not preempt.
// - class A traps: nonmaskable 0x08, stack over 0x10, stack under 0x18.
// - five class B traps share vector 0x28, each with own flag.
// - hardware, software and watchdog reset restart at 0x0000, no flag set.
// - software trap takes number 00..7F, vector number times four, keeps priority.
// - software may raise a node by writing its request flag to one.
// - each source has one of sixteen levels; only higher level preempts.
// - stack accesses compare pointer with both limits and raise stack traps.
package itv_pkg;
   localparam int ITV_NODES = 30;
   localparam logic [7:0] ITV_PADDR_W = 8'h08;
   // register byte offsets
   localparam logic [7:0] ITV_REG_REQ = 8'h00;     // node request flags, write one sets
   localparam logic [7:0] ITV_REG_REQCLR = 8'h04;  // write one clears request flags
   localparam logic [7:0] ITV_REG_ENA = 8'h08;     // node enable flags
   localparam logic [7:0] ITV_REG_TFR = 8'h0C;     // trap flag register, write one clears
   localparam logic [7:0] ITV_REG_LIMHI = 8'h10;   // stack upper limit
   localparam logic [7:0] ITV_REG_LIMLO = 8'h14;   // stack lower limit
   localparam logic [7:0] ITV_REG_VEC = 8'h18;     // current vector, number and level
   localparam logic [7:0] ITV_REG_IRQST = 8'h1C;   // sticky event status, read only
   localparam logic [7:0] ITV_REG_IRQCLR = 8'h20;  // write one clears event status
   localparam logic [7:0] ITV_REG_IRQEN = 8'h24;   // event interrupt enable
   localparam logic [7:0] ITV_REG_PRIO0 = 8'h40;   // level of node n at 0x40 + 4n
   localparam logic [15:0] ITV_LIMHI_RST = 16'h0000;
   localparam logic [15:0] ITV_LIMLO_RST = 16'hFFFF;
   // trap numbers
   localparam logic [6:0] ITV_TN_RESET = 7'h00;
   localparam logic [6:0] ITV_TN_NMI = 7'h02;
   localparam logic [6:0] ITV_TN_STACK_UPPER_LIMIT = 7'h04;
   localparam logic [6:0] ITV_TN_STACK_LOWER_LIMIT = 7'h06;
   localparam logic [6:0] ITV_TN_CLASSB = 7'h0A;
   // trap flag bit positions
   localparam int ITV_TF_NMI = 15;
   localparam int ITV_TF_OVER = 14;
   localparam int ITV_TF_UNDER = 13;
   localparam int ITV_TF_BUS = 7;
   localparam int ITV_TF_INSTR = 3;
   localparam int ITV_TF_OPER = 2;
   localparam int ITV_TF_PROT = 1;
   localparam int ITV_TF_OPC = 0;
   // trap number of each node, in node order
   localparam logic [6:0] ITV_NODE_TN [ITV_NODES] = '{
      7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D, 7'h1E, 7'h1F, 7'h22, 7'h23,
      7'h24, 7'h25, 7'h26, 7'h27, 7'h28, 7'h29, 7'h2A, 7'h47, 7'h2B, 7'h2C,
      7'h2D, 7'h2E, 7'h2F, 7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46};
   typedef enum logic [1:0] {
      ITV_RUN = 2'b00,
      ITV_INT = 2'b01,
      ITV_TRAP = 2'b10
   } itv_mode_e;
   typedef struct packed {
      logic nmi;
      logic opcode;
      logic prot;
      logic oper;
      logic instr;
      logic bus;
   } itv_trap_s;
   typedef struct packed {
      logic valid;
      logic [6:0] num;
      logic [3:0] level;
      logic [8:0] addr;
   } itv_vec_s;
endpackage

// >>> hdl/itv_core.sv
// interrupt node and hardware trap vectoring logic with apb registers
module itv_core (
   input wire logic i_core_clk,                   // cpu clock
   input wire logic i_rst_n,                      // async reset, active low
   input wire logic [31:0] i_paddr,               // apb address
   input wire logic i_psel,                       // apb select
   input wire logic i_penable,                    // apb enable
   input wire logic i_pwrite,                     // apb direction
   input wire logic [31:0] i_pwdata,              // apb write data
   output logic [31:0] o_prdata,                  // apb read data
   output logic o_pready,                         // apb ready
   output logic o_pslverr,                        // apb error
   input wire logic [itv_pkg::ITV_NODES-1:0] i_node_evt, // peripheral request pulses
   input wire logic i_nmi_evt,                    // nonmaskable event pulse
   input wire itv_pkg::itv_trap_s i_trap_evt,     // class b events (nmi field unused)
   input wire logic i_sw_reset,                   // software or watchdog restart pulse
   input wire logic i_stk_acc,                    // stack access strobe
   input wire logic [15:0] i_stk_ptr,             // stack pointer at access
   input wire logic i_swtrap,                     // software trap instruction pulse
   input wire logic [6:0] i_swtrap_num,           // software trap number
   input wire logic [3:0] i_cpu_level,            // current cpu priority
   input wire logic i_svc_done,                   // return from service pulse
   output itv_pkg::itv_vec_s o_vec,               // vector request to the core
   output logic o_trap_active,                    // hardware trap service running
   output logic o_irq                             // event interrupt line
);
   import itv_pkg::*;
   localparam int N = ITV_NODES;

   logic [N-1:0] req_r, ena_r;
   logic [15:0] tfr_r, limhi_r, limlo_r;
   logic [3:0] lvl_r [N];
   logic [3:0] irqst_r, irqen_r;
   itv_mode_e mode_r;
   logic [1:0] trap_cls_r; // 2 = class a, 1 = class b
   itv_vec_s vec_r;
   logic [31:0] prdata_r;
   logic ready_r, err_r;
   logic trap_act_r; // registered copy of trap service mode

   // apb decode
   wire acc = i_psel && !i_penable;
   wire wr = acc && i_pwrite;
   wire [7:0] a = i_paddr[7:0];
   wire hi_ok = (i_paddr[31:8] == 24'h000000);
   wire prio_hit = hi_ok && (a >= ITV_REG_PRIO0) && (a < ITV_REG_PRIO0 + 8'(4 * N)) && (a[1:0] == 2'b00);
   wire [4:0] prio_idx = 5'((a - ITV_REG_PRIO0) >> 2);
   wire std_hit = hi_ok && (a <= ITV_REG_IRQEN) && (a[1:0] == 2'b00);
   wire hit = std_hit || prio_hit;
   wire w_req = wr && hi_ok && a == ITV_REG_REQ;
   wire w_reqclr = wr && hi_ok && a == ITV_REG_REQCLR;
   wire w_ena = wr && hi_ok && a == ITV_REG_ENA;
   wire w_tfr = wr && hi_ok && a == ITV_REG_TFR;
   wire w_limhi = wr && hi_ok && a == ITV_REG_LIMHI;
   wire w_limlo = wr && hi_ok && a == ITV_REG_LIMLO;
   wire w_irqclr = wr && hi_ok && a == ITV_REG_IRQCLR;
   wire w_irqen = wr && hi_ok && a == ITV_REG_IRQEN;

   // stack limit checks
   wire stk_over = i_stk_acc && (i_stk_ptr < limhi_r);
   wire stk_under = i_stk_acc && (i_stk_ptr > limlo_r);

   // new trap flag bits, each kind its own bit
   logic [15:0] tf_set;
   always_comb begin
      tf_set = 16'h0000;
      tf_set[ITV_TF_NMI] = i_nmi_evt;
      tf_set[ITV_TF_OVER] = stk_over;
      tf_set[ITV_TF_UNDER] = stk_under;
      tf_set[ITV_TF_BUS] = i_trap_evt.bus;
      tf_set[ITV_TF_INSTR] = i_trap_evt.instr;
      tf_set[ITV_TF_OPER] = i_trap_evt.oper;
      tf_set[ITV_TF_PROT] = i_trap_evt.prot;
      tf_set[ITV_TF_OPC] = i_trap_evt.opcode;
   end
   wire [15:0] tfr_nxt = tf_set | (tfr_r & ~(w_tfr ? i_pwdata[15:0] : 16'h0000));

   // pending trap choice, class a before class b
   wire cls_a = tfr_r[ITV_TF_NMI] | tfr_r[ITV_TF_OVER] | tfr_r[ITV_TF_UNDER];
   wire cls_b = |{tfr_r[ITV_TF_BUS], tfr_r[ITV_TF_INSTR], tfr_r[ITV_TF_OPER], tfr_r[ITV_TF_PROT], tfr_r[ITV_TF_OPC]};
   wire [6:0] trap_tn = tfr_r[ITV_TF_NMI] ? ITV_TN_NMI : tfr_r[ITV_TF_OVER] ? ITV_TN_STACK_UPPER_LIMIT :
                        tfr_r[ITV_TF_UNDER] ? ITV_TN_STACK_LOWER_LIMIT : ITV_TN_CLASSB;
   wire [1:0] trap_rank = cls_a ? 2'd2 : cls_b ? 2'd1 : 2'd0;
   // trap taken unless equal or higher trap service running, no masking
   wire trap_go = (trap_rank != 2'd0) && (mode_r != ITV_TRAP || trap_rank > trap_cls_r) && !vec_r.valid;

   // highest level enabled request, lowest node wins a tie
   logic [4:0] best_idx;
   logic [3:0] best_lvl;
   logic best_vld;
   always_comb begin
      best_idx = 5'd0;
      best_lvl = 4'h0;
      best_vld = 1'b0;
      for (int k = 0; k < N; k++) begin
         if (req_r[k] && ena_r[k] && (!best_vld || lvl_r[k] > best_lvl)) begin
            best_idx = 5'(k);
            best_lvl = lvl_r[k];
            best_vld = 1'b1;
         end
      end
   end
   // node taken only above current level and never during trap service
   wire int_go = best_vld && (best_lvl > i_cpu_level) && (mode_r != ITV_TRAP) && !trap_go && !vec_r.valid;
   wire sw_go = i_swtrap && !trap_go && !vec_r.valid;

   // request flags: hardware and software set, set wins over clear
   wire [N-1:0] req_ack = int_go ? (N'(1) << best_idx) : '0;
   wire [N-1:0] req_set = i_node_evt | (w_req ? i_pwdata[N-1:0] : '0);
   wire [N-1:0] req_nxt = req_set | (req_r & ~req_ack & ~(w_reqclr ? i_pwdata[N-1:0] : '0));

   wire [3:0] evt = {i_sw_reset, trap_go, int_go, sw_go};
   wire [3:0] irqst_nxt = evt | (irqst_r & ~(w_irqclr ? i_pwdata[3:0] : 4'h0));

   // vector choice; vector is trap number times four
   itv_vec_s vec_nxt;
   always_comb begin
      vec_nxt = vec_r;
      vec_nxt.valid = 1'b0;
      if (i_sw_reset) begin
         vec_nxt = '{valid: 1'b1, num: ITV_TN_RESET, level: 4'hF, addr: {ITV_TN_RESET, 2'b00}};
      end else if (trap_go) begin
         vec_nxt = '{valid: 1'b1, num: trap_tn, level: 4'hF, addr: {trap_tn, 2'b00}};
      end else if (int_go) begin
         vec_nxt = '{valid: 1'b1, num: ITV_NODE_TN[best_idx], level: best_lvl,
                     addr: {ITV_NODE_TN[best_idx], 2'b00}};
      end else if (sw_go) begin
         vec_nxt = '{valid: 1'b1, num: i_swtrap_num, level: i_cpu_level, addr: {i_swtrap_num, 2'b00}};
      end
   end

   // read mux
   logic [31:0] rd;
   always_comb begin
      rd = 32'h00000000;
      if (prio_hit) rd = {28'h0000000, lvl_r[prio_idx]};
      else if (a == ITV_REG_REQ) rd = 32'(req_r);
      else if (a == ITV_REG_ENA) rd = 32'(ena_r);
      else if (a == ITV_REG_TFR) rd = {16'h0000, tfr_r};
      else if (a == ITV_REG_LIMHI) rd = {16'h0000, limhi_r};
      else if (a == ITV_REG_LIMLO) rd = {16'h0000, limlo_r};
      else if (a == ITV_REG_VEC) rd = {10'h000, mode_r, vec_r.level, vec_r.num, vec_r.addr[8:0]};
      else if (a == ITV_REG_IRQST) rd = {28'h0000000, irqst_r};
      else if (a == ITV_REG_IRQEN) rd = {28'h0000000, irqen_r};
   end

   // service mode tracking
   itv_mode_e mode_nxt;
   always_comb begin
      mode_nxt = mode_r;
      if (i_sw_reset) mode_nxt = ITV_RUN;
      else if (trap_go) mode_nxt = ITV_TRAP;
      else if (int_go) mode_nxt = ITV_INT;
      else if (i_svc_done) mode_nxt = ITV_RUN;
   end

   // state and registers
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         req_r <= '0;
         ena_r <= '0;
         tfr_r <= 16'h0000;
         limhi_r <= ITV_LIMHI_RST;
         limlo_r <= ITV_LIMLO_RST;
         irqst_r <= 4'h0;
         irqen_r <= 4'h0;
         mode_r <= ITV_RUN;
         trap_act_r <= 1'b0;
         trap_cls_r <= 2'd0;
         vec_r <= '{valid: 1'b1, num: ITV_TN_RESET, level: 4'hF, addr: 9'h000};
      end else begin
         req_r <= req_nxt;
         tfr_r <= tfr_nxt;
         irqst_r <= irqst_nxt;
         mode_r <= mode_nxt;
         trap_act_r <= (mode_nxt == ITV_TRAP);   // output straight from a flop
         vec_r <= vec_nxt;
         if (trap_go) trap_cls_r <= trap_rank;
         else if (mode_nxt != ITV_TRAP) trap_cls_r <= 2'd0;
         if (w_ena) ena_r <= i_pwdata[N-1:0];
         if (w_limhi) limhi_r <= i_pwdata[15:0];
         if (w_limlo) limlo_r <= i_pwdata[15:0];
         if (w_irqen) irqen_r <= i_pwdata[3:0];
      end
   end

   // node priority levels
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int k = 0; k < N; k++) lvl_r[k] <= 4'h0;
      end else if (wr && prio_hit) begin
         lvl_r[prio_idx] <= i_pwdata[3:0];
      end
   end

   // apb answer one cycle after setup
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prdata_r <= 32'h00000000;
         ready_r <= 1'b0;
         err_r <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         ready_r <= acc;
         err_r <= acc && !hit;
         if (acc && !i_pwrite) prdata_r <= hit ? rd : 32'h00000000;
         o_irq <= |(irqst_nxt & irqen_r);
      end
   end

   assign o_prdata = prdata_r;
   assign o_pready = ready_r;
   assign o_pslverr = err_r;
   assign o_vec = vec_r;
   assign o_trap_active = trap_act_r;

   // trap vector issued one cycle after a trap is taken, unless a reset pulse wins
   a_trap_vector_go: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      trap_go && !i_sw_reset |=> o_vec.valid && o_vec.addr == {$past(trap_tn), 2'b00})
      else $error("trap vector not issued");
   a_nmi_flag_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_nmi_evt |=> tfr_r[ITV_TF_NMI])
      else $error("nmi flag missing");
   a_trap_no_preempt: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_trap_active |-> !int_go)
      else $error("interrupt during trap service");
   a_class_b_vec: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      trap_go && !cls_a && !i_sw_reset |=> o_vec.num == ITV_TN_CLASSB)
      else $error("class b vector wrong");
   a_reset_vec_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_sw_reset |=> o_vec.valid && o_vec.addr == 9'h000 && $stable(tfr_r & ~16'($past(tf_set))))
      else $error("reset vector wrong");
   a_swtrap_addr: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      sw_go && !i_sw_reset |=> o_vec.addr == {$past(i_swtrap_num), 2'b00} && o_vec.level == $past(i_cpu_level))
      else $error("software trap vector wrong");
   a_int_level_above: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      int_go |-> best_lvl > i_cpu_level ##1 o_vec.level > $past(i_cpu_level))
      else $error("low level interrupt accepted");
   a_stack_over_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_stk_acc && i_stk_ptr < limhi_r |=> tfr_r[ITV_TF_OVER])
      else $error("stack overflow not flagged");
   a_sw_request_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      w_req && i_pwdata[0] |=> req_r[0] || $past(int_go && best_idx == 5'd0))
      else $error("software request lost");
endmodule

// >>> sim/itv_cpu_model.sv
// behavioural core that returns from each vectored service
module itv_cpu_model (
   input wire logic i_clk,       // cpu clock
   input wire logic i_rst_n,     // async reset, active low
   input wire logic i_vec_valid, // vector handed to the core
   input wire logic i_slow,      // long service routine
   input wire logic i_hold,      // keep services running
   output logic o_done           // return from service pulse
);
   logic live_r;
   logic [3:0] depth_r;
   logic [3:0] cnt_r;
   // count nested services, end the newest after its run time
   // the reset vector is no service, so the first edge is skipped
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         live_r <= 1'b0;
         depth_r <= 4'h0;
         cnt_r <= 4'h0;
         o_done <= 1'b0;
      end else begin
         live_r <= 1'b1;
         o_done <= 1'b0;
         if (i_vec_valid && live_r) begin
            depth_r <= depth_r + 4'h1;
            cnt_r <= i_slow ? 4'h6 : 4'h1;
         end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
         end else if (depth_r != 4'h0 && !i_hold && !o_done) begin
            o_done <= 1'b1;
            depth_r <= depth_r - 4'h1;
         end
      end
   end
endmodule

// >>> sim/tb_interrupt_trap_vectoring.sv
// self-checking bench for the interrupt and trap vectoring block
module tb_interrupt_trap_vectoring;
   timeunit 1ns;
   timeprecision 1ps;
   import itv_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ITV_NODES-1:0] node_evt = '0;
   logic nmi_evt = 1'b0, sw_reset = 1'b0, stk_acc = 1'b0, swtrap = 1'b0;
   itv_trap_s trap_evt = '0;
   logic [15:0] stk_ptr = '0;
   logic [6:0] swtrap_num = '0;
   logic [3:0] cpu_level = '0;
   logic svc_done, pready, pslverr, trap_active, irq, perr;
   logic slow = 1'b0, hold = 1'b0;
   logic [31:0] prdata;
   itv_vec_s vec;
   int n_errors = 0;
   int total_checks = 0;
   int tf_pos [5] = '{ITV_TF_BUS, ITV_TF_INSTR, ITV_TF_OPER, ITV_TF_PROT, ITV_TF_OPC};
   logic [6:0] sw_tn [3] = '{7'h00, 7'h35, 7'h7F};

   always #4 clk = ~clk;

   itv_core dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_paddr(paddr), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_node_evt(node_evt), .i_nmi_evt(nmi_evt), .i_trap_evt(trap_evt), .i_sw_reset(sw_reset),
      .i_stk_acc(stk_acc), .i_stk_ptr(stk_ptr), .i_swtrap(swtrap), .i_swtrap_num(swtrap_num),
      .i_cpu_level(cpu_level), .i_svc_done(svc_done), .o_vec(vec), .o_trap_active(trap_active), .o_irq(irq));

   itv_cpu_model core (.i_clk(clk), .i_rst_n(rst_n), .i_vec_valid(vec.valid), .i_slow(slow), .i_hold(hold),
      .o_done(svc_done));

   // verdict and end of run
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer, held until pready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      i = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask

   // wait for the next vector and check number and address
   task automatic wait_vec(input logic [6:0] tn);
      int i;
      i = 0;
      do begin
         @(negedge clk);
         i++;
      end while (vec.valid !== 1'b1 && i < 60);
      chk(32'(vec.valid), 32'h1);
      chk(32'(vec.num), 32'(tn));
      chk(32'(vec.addr), {23'h0, tn, 2'b00});
   endtask

   task automatic no_vec();
      logic seen;
      seen = 1'b0;
      repeat (12) begin
         @(negedge clk);
         if (vec.valid === 1'b1) seen = 1'b1;
      end
      chk(32'(seen), 32'h0);
   endtask

   // one event pulse: bit 5 nonmaskable, bits 4..0 class b
   task automatic kick(input logic [5:0] t);
      @(posedge clk);
      nmi_evt <= t[5];
      trap_evt <= itv_trap_s'(t);
      @(posedge clk);
      nmi_evt <= 1'b0;
      trap_evt <= '0;
   endtask

   task automatic stk(input logic [15:0] p);
      @(posedge clk);
      stk_acc <= 1'b1;
      stk_ptr <= p;
      @(posedge clk);
      stk_acc <= 1'b0;
   endtask

   // let the core end exactly one service
   task automatic release1();
      @(posedge clk);
      hold <= 1'b0;
      @(posedge clk);
      hold <= 1'b1;
   endtask

   initial begin
      #300000;
      n_errors++;
      close_out();
   end

   initial begin
      repeat (2) @(negedge clk);
      chk(32'(vec.valid), 32'h1);
      chk(32'(vec.addr), 32'h0);
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(ITV_REG_LIMHI, 32'h0);
      rd(ITV_REG_LIMLO, 32'hFFFF);
      rd(ITV_REG_TFR, 32'h0);
      rd(8'h30, 32'h0);
      chk(32'(perr), 32'h1);
      wr(ITV_REG_ENA, 32'h3FFF_FFFF);
      for (int n = 0; n < ITV_NODES; n++) wr(ITV_REG_PRIO0 + 8'(4 * n), 32'h1);
      // nonmaskable trap, event interrupt, stack traps
      hold <= 1'b1;
      wr(ITV_REG_IRQCLR, 32'hF);
      kick(6'h20);
      wait_vec(ITV_TN_NMI);
      chk(32'(trap_active), 32'h1);
      rd(ITV_REG_TFR, 32'h8000);
      rd(ITV_REG_IRQST, 32'h4);
      chk(32'(irq), 32'h0);
      wr(ITV_REG_IRQEN, 32'h4);
      @(negedge clk);
      chk(32'(irq), 32'h1);
      wr(ITV_REG_IRQCLR, 32'h4);
      @(negedge clk);
      chk(32'(irq), 32'h0);
      wr(ITV_REG_LIMHI, 32'h100);
      wr(ITV_REG_LIMLO, 32'h200);
      stk(16'h00F0);
      no_vec();
      wr(ITV_REG_TFR, 32'h8000);
      release1();
      wait_vec(ITV_TN_STACK_UPPER_LIMIT);
      rd(ITV_REG_TFR, 32'h4000);
      wr(ITV_REG_TFR, 32'hFFFF);
      release1();
      stk(16'h0210);
      wait_vec(ITV_TN_STACK_LOWER_LIMIT);
      rd(ITV_REG_TFR, 32'h2000);
      wr(ITV_REG_TFR, 32'hFFFF);
      release1();
      stk(16'h0150);
      no_vec();
      // every class b kind on the shared vector
      for (int k = 0; k < 5; k++) begin
         kick(6'(1 << k));
         wait_vec(ITV_TN_CLASSB);
         rd(ITV_REG_TFR, 32'h1 << tf_pos[k]);
         wr(ITV_REG_TFR, 32'hFFFF);
         release1();
      end
      // class a over class b, nodes held off during traps
      kick(6'h10);
      wait_vec(ITV_TN_CLASSB);
      kick(6'h20);
      wait_vec(ITV_TN_NMI);
      wr(ITV_REG_REQ, 32'h1);
      no_vec();
      wr(ITV_REG_TFR, 32'hFFFF);
      hold <= 1'b0;
      wait_vec(ITV_NODE_TN[0]);
      for (int n = 0; n < ITV_NODES; n++) begin
         slow <= 1'(n % 2);
         wr(ITV_REG_REQ, 32'h1 << n);
         wait_vec(ITV_NODE_TN[n]);
      end
      @(posedge clk);
      node_evt[17] <= 1'b1;
      @(posedge clk);
      node_evt[17] <= 1'b0;
      wait_vec(7'h47);
      wr(ITV_REG_ENA, 32'h0);
      wr(ITV_REG_REQ, 32'h1);
      no_vec();
      wr(ITV_REG_ENA, 32'h3FFF_FFFF);
      wait_vec(7'h18);
      wr(ITV_REG_PRIO0 + 8'h0C, 32'h5);
      wr(ITV_REG_PRIO0 + 8'h1C, 32'h9);
      wr(ITV_REG_REQ, 32'h88);
      wait_vec(7'h1F);
      wait_vec(7'h1B);
      cpu_level <= 4'h9;
      wr(ITV_REG_REQ, 32'h8);
      no_vec();
      cpu_level <= 4'h0;
      wait_vec(7'h1B);
      // software traps keep the cpu level
      cpu_level <= 4'h3;
      for (int t = 0; t < 3; t++) begin
         @(posedge clk);
         swtrap <= 1'b1;
         swtrap_num <= sw_tn[t];
         @(posedge clk);
         swtrap <= 1'b0;
         wait_vec(sw_tn[t]);
         chk(32'(vec.level), 32'h3);
      end
      @(posedge clk);
      sw_reset <= 1'b1;
      @(posedge clk);
      sw_reset <= 1'b0;
      wait_vec(ITV_TN_RESET);
      rd(ITV_REG_TFR, 32'h0);
      repeat (20) @(posedge clk);
      close_out();
   end
endmodule
